// ==== hw/dft_pkg.sv ====
// Shared constants, types and register map of the drive fault trip manager.
package dft_pkg;

    // Clock and documented times.
    localparam int CLK_HZ         = 20_000_000;
    localparam int EXT_RES_MIN_MS = 100;
    localparam int RECOVER_MS     = 1000;
    localparam int FLICKER_MS     = 250;
    // A least time gets one cycle more than its exact count.
    localparam int EXT_RES_MIN_CYC = (EXT_RES_MIN_MS * (CLK_HZ / 1000)) + 1;
    localparam int RECOVER_CYC     = RECOVER_MS * (CLK_HZ / 1000);
    localparam int FLICKER_CYC     = FLICKER_MS * (CLK_HZ / 1000);
    localparam int CNT_W           = 26;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_FCODE    = 8'h08;
    localparam logic [7:0] REG_INT_STAT = 8'h0c;
    localparam logic [7:0] REG_INT_CLR  = 8'h10;
    localparam logic [7:0] REG_INT_EN   = 8'h14;
    localparam logic [7:0] REG_THERM    = 8'h18;
    localparam logic [7:0] REG_TH_LIMIT = 8'h1c;
    localparam logic [7:0] REG_RETRY    = 8'h20;
    localparam logic [7:0] REG_HIST_SEL = 8'h24;
    localparam logic [7:0] REG_HIST_DAT = 8'h28;

    // Field positions and reset values.
    localparam int          CTRL_ALARM_EN = 0;
    localparam logic [15:0] TH_LIMIT_RST  = 16'hc000;
    localparam logic [15:0] THERM_DECAY   = 16'h0001;
    localparam int          HIST_DEPTH    = 8;
    localparam int          HIST_AW       = 3;

    // Interrupt status bit positions.
    localparam int IRQ_W     = 5;
    localparam int IRQ_FAULT = 0;
    localparam int IRQ_WARN  = 1;
    localparam int IRQ_ALARM = 2;
    localparam int IRQ_MSG   = 3;
    localparam int IRQ_READY = 4;

    // Fault codes.
    localparam logic [7:0] FC_NONE    = 8'h00;
    localparam logic [7:0] FC_OC_BASE = 8'h10;
    localparam logic [7:0] FC_OV_BASE = 8'h20;
    localparam logic [7:0] FC_BRAKE   = 8'h70;

    typedef enum logic [1:0]
    {
        MOT_ACCEL = 2'b00,
        MOT_CONST = 2'b01,
        MOT_DECEL = 2'b10
    } dft_motion_t;

    typedef enum logic [1:0]
    {
        ST_RUN     = 2'b00,
        ST_TRIPPED = 2'b01,
        ST_HOLD    = 2'b10,
        ST_RECOVER = 2'b11
    } dft_state_t;

    typedef struct packed
    {
        logic overcurrent;
        logic overvolt;
        logic brake_transistor;
        logic internal_circuit;
    } dft_fault_t;

    typedef struct packed
    {
        logic stall_prev_current_warn;
        logic stall_prev_voltage_warn;
        logic regen_brake_prealarm;
        logic panel_stop_warn;
        logic maintenance_warn;
        logic param_copy_warn;
    } dft_warn_t;

    typedef struct packed
    {
        logic password_lock_msg;
        logic param_write_err_msg;
        logic copy_op_err_msg;
    } dft_msg_t;

endpackage

// ==== hw/dft_fault_hist.sv ====
// Eight-deep history of latched fault codes, newest first.
`timescale 1ns/1ps
module dft_fault_hist #(
    parameter int DEPTH = dft_pkg::HIST_DEPTH,
    parameter int AW    = dft_pkg::HIST_AW
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          rst_b,
    // Write side
    input  wire logic          push,
    input  wire logic [7:0]    code,
    // Read side
    input  wire logic [AW-1:0] sel,
    output logic      [7:0]    entry
);
    import dft_pkg::*;

    logic [7:0]    mem [DEPTH];
    logic [AW-1:0] wr_ptr;

    // The oldest entry is simply overwritten once all slots are used.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            wr_ptr <= '0;
        else if (push)
            wr_ptr <= wr_ptr + 1'b1;
    end

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++)
        begin : g_slot
            always_ff @(posedge clk_sys)
            begin
                if (!rst_b)
                    mem[gi] <= FC_NONE;
                else if (push && wr_ptr == AW'(gi))
                    mem[gi] <= code;
            end
        end
    endgenerate

    // Selector 0 is the newest fault.
    assign entry = mem[AW'(wr_ptr - sel - 1'b1)];

endmodule

// ==== hw/dft_trip_manager.sv ====
// Fault classifier, trip control, reset handling and registers.
`timescale 1ns/1ps
module dft_trip_manager #(
    parameter int EXT_RES_CYC = dft_pkg::EXT_RES_MIN_CYC,
    parameter int RECOV_CYC   = dft_pkg::RECOVER_CYC,
    parameter int FLICK_CYC   = dft_pkg::FLICKER_CYC
) (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_b,
    // Register port
    input  wire logic [7:0]           reg_addr,
    input  wire logic [31:0]          reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [31:0]          reg_rdata,
    // Reset sources and start command
    input  wire logic                 ext_reset_in,
    input  wire logic                 panel_reset_key,
    input  wire logic                 power_ok,
    input  wire logic                 start_cmd,
    // Condition inputs
    input  wire dft_pkg::dft_motion_t motion,
    input  wire dft_pkg::dft_fault_t  fault_in,
    input  wire dft_pkg::dft_warn_t   warn_in,
    input  wire dft_pkg::dft_msg_t    msg_in,
    input  wire logic                 fan_alarm,
    input  wire logic [7:0]           thermal_load,
    input  wire logic                 retry_pulse,
    // Outputs
    output logic                      drive_enable,
    output logic                      fault_out,
    output logic                      alarm_out,
    output logic                      warn_ind,
    output logic                      msg_ind,
    output logic                      reset_flicker,
    output logic      [7:0]           fault_code,
    output logic                      irq
);
    import dft_pkg::*;

    dft_state_t       state;
    dft_state_t       next_state;
    logic [CNT_W-1:0] ext_cnt;
    logic [CNT_W-1:0] rec_cnt;
    logic [CNT_W-1:0] flk_cnt;
    logic [15:0]      therm;
    logic [15:0]      th_limit;
    logic [7:0]       retry_cnt;
    logic             alarm_en;
    logic [IRQ_W-1:0] int_stat;
    logic [IRQ_W-1:0] int_en;
    logic [HIST_AW-1:0] hist_sel;
    logic [7:0]       hist_entry;
    logic [7:0]       next_code;
    logic             fault_hit;
    logic             ext_valid;
    logic             in_reset;
    logic             thermal_prealarm;
    logic             any_warn;
    logic             warn_q;
    logic             alarm_q;
    logic             msg_q;
    logic [IRQ_W-1:0] irq_evt;
    logic [16:0]      therm_sum;

    // Fault priority and code selection; first match wins.
    always_comb
    begin
        fault_hit = 1'b1;
        next_code = FC_NONE;
        if (fault_in.overcurrent)
            next_code = FC_OC_BASE + 8'(motion);
        else if (fault_in.overvolt)
            next_code = FC_OV_BASE + 8'(motion);
        else if (fault_in.brake_transistor || fault_in.internal_circuit)
            next_code = FC_BRAKE;
        else
            fault_hit = 1'b0;
    end

    assign ext_valid = (ext_cnt >= CNT_W'(EXT_RES_CYC));
    assign in_reset  = (state == ST_HOLD);
    assign thermal_prealarm = (therm >= th_limit);
    assign any_warn  = (|warn_in) || thermal_prealarm;

    // External reset hold timer.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || !ext_reset_in)
            ext_cnt <= '0;
        else if (!ext_valid)
            ext_cnt <= ext_cnt + 1'b1;
    end

    always_comb
    begin
        next_state = state;
        case (state)
            ST_RUN:
                if (!power_ok || ext_valid)
                    next_state = ST_HOLD;
                else if (fault_hit)
                    next_state = ST_TRIPPED;
            ST_TRIPPED:
                if (!power_ok || ext_valid || panel_reset_key)
                    next_state = ST_HOLD;
            ST_HOLD:
                if (power_ok && !ext_reset_in)
                    next_state = ST_RECOVER;
            ST_RECOVER:
                if (!power_ok || ext_valid)
                    next_state = ST_HOLD;
                else if (rec_cnt >= CNT_W'(RECOV_CYC - 1))
                    next_state = ST_RUN;
            default:
                next_state = ST_HOLD;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            state <= ST_HOLD;
        else
            state <= next_state;
    end

    // Recovery delay after any reset is released.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || state != ST_RECOVER)
            rec_cnt <= '0;
        else
            rec_cnt <= rec_cnt + 1'b1;
    end

    // Status flicker while the external reset is held.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || !(in_reset && ext_reset_in))
        begin
            flk_cnt       <= '0;
            reset_flicker <= 1'b0;
        end
        else if (flk_cnt >= CNT_W'(FLICK_CYC - 1))
        begin
            flk_cnt       <= '0;
            reset_flicker <= !reset_flicker;
        end
        else
            flk_cnt <= flk_cnt + 1'b1;
    end

    // Latched code and trip outputs.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || in_reset)
        begin
            fault_code <= FC_NONE;
            fault_out  <= 1'b0;
        end
        else if (state == ST_RUN && next_state == ST_TRIPPED)
        begin
            fault_code <= next_code;
            fault_out  <= 1'b1;
        end
    end

    // A start held across a reset restarts the motor the moment
    // recovery ends; the controller has to drop it first.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            drive_enable <= 1'b0;
        else
            drive_enable <= (next_state == ST_RUN) && start_cmd;
    end

    // Indications that never trip the output.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            warn_ind  <= 1'b0;
            msg_ind   <= 1'b0;
            alarm_out <= 1'b0;
        end
        else
        begin
            warn_ind  <= any_warn;
            msg_ind   <= |msg_in;
            alarm_out <= fan_alarm && alarm_en;
        end
    end

    // Thermal integrator with slow decay; saturates rather than wraps.
    assign therm_sum = {1'b0, therm} + {9'h000, thermal_load};
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || in_reset)
            therm <= '0;
        else if (therm_sum[16])
            therm <= 16'hffff;
        else if (therm_sum[15:0] >= THERM_DECAY)
            therm <= therm_sum[15:0] - THERM_DECAY;
        else
            therm <= '0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || in_reset)
            retry_cnt <= '0;
        else if (retry_pulse && retry_cnt != 8'hff)
            retry_cnt <= retry_cnt + 1'b1;
    end

    // Fault history.
    dft_fault_hist #(
        .DEPTH (HIST_DEPTH),
        .AW    (HIST_AW)
    ) u_hist (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .push    (state == ST_RUN && next_state == ST_TRIPPED),
        .code    (next_code),
        .sel     (hist_sel),
        .entry   (hist_entry)
    );

    // Interrupt events are rising edges of each class.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            warn_q  <= 1'b0;
            alarm_q <= 1'b0;
            msg_q   <= 1'b0;
        end
        else
        begin
            warn_q  <= any_warn;
            alarm_q <= fan_alarm;
            msg_q   <= |msg_in;
        end
    end

    always_comb
    begin
        irq_evt            = '0;
        irq_evt[IRQ_FAULT] = (state == ST_RUN) && (next_state == ST_TRIPPED);
        irq_evt[IRQ_WARN]  = any_warn && !warn_q;
        irq_evt[IRQ_ALARM] = fan_alarm && !alarm_q;
        irq_evt[IRQ_MSG]   = (|msg_in) && !msg_q;
        irq_evt[IRQ_READY] = (state == ST_RECOVER) && (next_state == ST_RUN);
    end

    // A new event beats a clear written in the same cycle.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            int_stat <= '0;
        else if (reg_wr && reg_addr == REG_INT_CLR)
            int_stat <= (int_stat & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
        else
            int_stat <= int_stat | irq_evt;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(int_stat & int_en);
    end

    // Register writes.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            alarm_en <= 1'b0;
            int_en   <= '0;
            th_limit <= TH_LIMIT_RST;
            hist_sel <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == REG_CTRL)
                alarm_en <= reg_wdata[CTRL_ALARM_EN];
            else if (reg_addr == REG_INT_EN)
                int_en <= reg_wdata[IRQ_W-1:0];
            else if (reg_addr == REG_TH_LIMIT)
                th_limit <= reg_wdata[15:0];
            else if (reg_addr == REG_HIST_SEL)
                hist_sel <= reg_wdata[HIST_AW-1:0];
        end
    end

    // Register reads; unmapped addresses and write-only read zero.
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b || !reg_rd)
            reg_rdata <= '0;
        else if (reg_addr == REG_CTRL)
            reg_rdata <= {31'h0, alarm_en};
        else if (reg_addr == REG_STATUS)
            reg_rdata <= {24'h0, thermal_prealarm, msg_ind, warn_ind,
                          alarm_out, fault_out, drive_enable, state};
        else if (reg_addr == REG_FCODE)
            reg_rdata <= {24'h0, fault_code};
        else if (reg_addr == REG_INT_STAT)
            reg_rdata <= {27'h0, int_stat};
        else if (reg_addr == REG_INT_EN)
            reg_rdata <= {27'h0, int_en};
        else if (reg_addr == REG_THERM)
            reg_rdata <= {16'h0, therm};
        else if (reg_addr == REG_TH_LIMIT)
            reg_rdata <= {16'h0, th_limit};
        else if (reg_addr == REG_RETRY)
            reg_rdata <= {24'h0, retry_cnt};
        else if (reg_addr == REG_HIST_SEL)
            reg_rdata <= {29'h0, hist_sel};
        else if (reg_addr == REG_HIST_DAT)
            reg_rdata <= {24'h0, hist_entry};
        else
            reg_rdata <= '0;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_short_res_ignored: assert property (
        (state == ST_RUN && power_ok && ext_cnt < CNT_W'(EXT_RES_CYC - 1)
         && !fault_hit) |=> state != ST_HOLD)
        else $error("reset taken before hold time");
    a_hold_while_res: assert property (
        (in_reset && ext_reset_in) |=> in_reset)
        else $error("left reset while input held");
    a_recover_not_early: assert property (
        (state == ST_RECOVER && rec_cnt < CNT_W'(RECOV_CYC - 1))
        |=> state != ST_RUN)
        else $error("resumed before recovery delay");
    a_reset_clears: assert property (
        in_reset |=> (therm == '0 && retry_cnt == '0 && fault_code == '0))
        else $error("reset did not clear state");
    a_key_ignored: assert property (
        (state == ST_RUN && panel_reset_key && power_ok && !ext_valid)
        |=> state != ST_HOLD)
        else $error("panel key acted without fault");
    a_power_loss: assert property (
        (!power_ok && state != ST_HOLD) |=> in_reset ##1 !fault_out)
        else $error("power loss did not reset");
    a_msg_no_trip: assert property (
        ((|msg_in) && !fault_hit && state == ST_RUN && power_ok
         && !ext_valid) |=> (state == ST_RUN && msg_ind))
        else $error("message tripped or not shown");
    a_alarm_gate: assert property (
        fan_alarm && alarm_en |=> alarm_out)
        else $error("alarm output missing");
    a_trip_outputs: assert property (
        (state == ST_RUN && fault_hit && power_ok && !ext_valid)
        |=> (fault_out && !drive_enable)[*2])
        else $error("fault did not trip output");
    a_oc_accel_code: assert property (
        (state == ST_RUN && fault_in.overcurrent && motion == MOT_ACCEL
         && power_ok && !ext_valid) |=> fault_code == 8'h10)
        else $error("wrong overcurrent code");
    a_first_latched: assert property (
        (state == ST_TRIPPED && next_state == ST_TRIPPED)
        |=> $stable(fault_code))
        else $error("latched code changed");

    c_trip: cover property (state == ST_RUN ##1 state == ST_TRIPPED);
    c_key_reset: cover property (state == ST_TRIPPED && panel_reset_key);
    c_ext_reset: cover property (in_reset && reset_flicker);
    c_resume: cover property (state == ST_RECOVER ##1 state == ST_RUN);

endmodule

// ==== testbench/dft_ctrl_model.sv ====
// Behavioural model of the external controller driving reset and start.
`timescale 1ns/1ps
module dft_ctrl_model
(
    // Clock
    input  wire logic clk_sys,
    // Controller outputs
    output logic      ext_reset_in,
    output logic      start_cmd
);
    initial
    begin
        ext_reset_in = 1'b0;
        start_cmd    = 1'b0;
    end

    // Start is dropped before any reset, else the motor restarts at once.
    task automatic stop();
        @(posedge clk_sys);
        start_cmd <= 1'b0;
    endtask

    task automatic run();
        @(posedge clk_sys);
        start_cmd <= 1'b1;
    endtask

    // A request only counts when held past the device's minimum hold time.
    task automatic pulse(input int n);
        stop();
        @(posedge clk_sys);
        ext_reset_in <= 1'b1;
        repeat (n) @(posedge clk_sys);
        ext_reset_in <= 1'b0;
    endtask
endmodule

// ==== testbench/dft_trip_manager_tb.sv ====
// Self-checking testbench of the drive fault trip manager.
`timescale 1ns/1ps
module dft_trip_manager_tb;
    import dft_pkg::*;
    localparam int EXT_C   = 10;
    localparam int RECOV_C = 20;
    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic        ext_reset_in;
    logic        panel_reset_key = 1'b0;
    logic        power_ok = 1'b1;
    logic        start_cmd;
    dft_motion_t motion = MOT_CONST;
    dft_fault_t  fault_in = '0;
    dft_warn_t   warn_in = '0;
    dft_msg_t    msg_in = '0;
    logic        fan_alarm = 1'b0;
    logic [7:0]  thermal_load = 8'h00;
    logic        retry_pulse = 1'b0;
    logic        drive_enable;
    logic        fault_out;
    logic        alarm_out;
    logic        warn_ind;
    logic        msg_ind;
    logic        reset_flicker;
    logic [7:0]  fault_code;
    logic        irq;
    int          n_errors = 0;
    int          n_compared = 0;
    int          n_flick = 0;
    integer      seed = 32'hbd11689c;
    logic [7:0]  hist[$];
    logic [31:0] d;
    logic [3:0]  f;
    logic [1:0]  m;

    always #25 clk_sys = ~clk_sys;

    always @(posedge clk_sys)
        if (reset_flicker === 1'b1)
            n_flick++;

    dft_ctrl_model i_dft_ctrl_model (.clk_sys(clk_sys),
        .ext_reset_in(ext_reset_in), .start_cmd(start_cmd));

    dft_trip_manager #(.EXT_RES_CYC(EXT_C), .RECOV_CYC(RECOV_C),
        .FLICK_CYC(3)) i_dft_trip_manager (.clk_sys(clk_sys),
        .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_reset_in(ext_reset_in), .panel_reset_key(panel_reset_key),
        .power_ok(power_ok), .start_cmd(start_cmd), .motion(motion),
        .fault_in(fault_in), .warn_in(warn_in), .msg_in(msg_in),
        .fan_alarm(fan_alarm), .thermal_load(thermal_load),
        .retry_pulse(retry_pulse), .drive_enable(drive_enable),
        .fault_out(fault_out), .alarm_out(alarm_out),
        .warn_ind(warn_ind), .msg_ind(msg_ind),
        .reset_flicker(reset_flicker), .fault_code(fault_code),
        .irq(irq));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("compares=%0d mismatches=%0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Fixed priority decides the code when several faults coincide.
    function automatic logic [7:0] exp_code(input logic [3:0] fv,
                                            input logic [1:0] mv);
        if (fv[3])
            return FC_OC_BASE + {6'h00, mv};
        if (fv[2])
            return FC_OV_BASE + {6'h00, mv};
        return FC_BRAKE;
    endfunction

    task automatic trip(input logic [3:0] fv, input logic [1:0] mv);
        logic [7:0] c;
        c = exp_code(fv, mv);
        @(posedge clk_sys);
        fault_in <= fv;
        motion   <= dft_motion_t'(mv);
        @(posedge clk_sys);
        fault_in <= 4'b1000;
        #1;
        chk(fault_out, 1'b1);
        chk(drive_enable, 1'b0);
        chk(fault_code, c);
        @(posedge clk_sys);
        fault_in <= '0;
        #1;
        chk(irq, 1'b1);
        rd(REG_FCODE, d);
        chk(d, {24'h0, c});
        wr(REG_INT_CLR, 32'h1);
        repeat (2) @(posedge clk_sys);
        #1;
        chk(irq, 1'b0);
        hist.push_front(c);
        if (hist.size() > HIST_DEPTH)
            void'(hist.pop_back());
    endtask

    task automatic do_reset(input int how);
        int cnt;
        i_dft_ctrl_model.stop();
        if (how == 0)
        begin
            @(posedge clk_sys);
            panel_reset_key <= 1'b1;
            @(posedge clk_sys);
            panel_reset_key <= 1'b0;
        end
        else if (how == 1)
        begin
            n_flick = 0;
            i_dft_ctrl_model.pulse(EXT_C - 5);
            repeat (3) @(posedge clk_sys);
            #1;
            chk(fault_out, 1'b1);
            chk(n_flick, 0);
            i_dft_ctrl_model.pulse(EXT_C + 8);
            chk(n_flick > 0, 1'b1);
        end
        else
        begin
            @(posedge clk_sys);
            power_ok <= 1'b0;
            repeat (3) @(posedge clk_sys);
            power_ok <= 1'b1;
        end
        // Counting starts at the release of the reset source.
        i_dft_ctrl_model.run();
        cnt = 1;
        while (drive_enable !== 1'b1 && cnt < 200)
        begin
            @(posedge clk_sys);
            #1;
            cnt++;
        end
        chk(cnt >= RECOV_C && cnt <= RECOV_C + 4, 1'b1);
        chk(fault_out, 1'b0);
        chk(fault_code, FC_NONE);
    endtask

    initial
    begin
        #2_000_000;
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        repeat (2) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(REG_TH_LIMIT, d);
        chk(d, {16'h0, TH_LIMIT_RST});
        rd(8'h3c, d);
        chk(d, 32'h0);
        wr(REG_INT_EN, 32'h1);
        do_reset(2);
        $display("test reset done");
        for (int i = 0; i < 10; i++)
        begin
            f = (i == 9) ? 4'b0110 : 4'b1000 >> (i % 4);
            m = 2'($unsigned($random(seed)) % 3);
            trip(f, m);
            do_reset(i % 3);
        end
        $display("test trips done");
        for (int s = 0; s < HIST_DEPTH; s++)
        begin
            wr(REG_HIST_SEL, s);
            rd(REG_HIST_DAT, d);
            chk(d, {24'h0, hist[s]});
        end
        $display("test history done");
        warn_in   <= 6'($random(seed)) | 6'h01;
        msg_in    <= 3'($random(seed)) | 3'h1;
        fan_alarm <= 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(warn_ind, 1'b1);
        chk(msg_ind, 1'b1);
        chk(alarm_out, 1'b0);
        chk(drive_enable, 1'b1);
        // Recovery left the ready bit set; each class rise adds its own.
        rd(REG_INT_STAT, d);
        chk(d, 32'h1e);
        wr(REG_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(alarm_out, 1'b1);
        chk(drive_enable, 1'b1);
        warn_in      <= '0;
        msg_in       <= '0;
        fan_alarm    <= 1'b0;
        thermal_load <= 8'hff;
        wr(REG_TH_LIMIT, 32'h100);
        repeat (4) @(posedge clk_sys);
        rd(REG_STATUS, d);
        chk(d[7], 1'b1);
        chk(drive_enable, 1'b1);
        thermal_load <= 8'h00;
        retry_pulse  <= 1'b1;
        @(posedge clk_sys);
        retry_pulse  <= 1'b0;
        rd(REG_RETRY, d);
        chk(d, 32'h1);
        panel_reset_key <= 1'b1;
        @(posedge clk_sys);
        panel_reset_key <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        chk(drive_enable, 1'b1);
        // The external reset case expects a latched fault to survive a too-short pulse.
        trip(4'b1000, 2'b00);
        do_reset(1);
        rd(REG_THERM, d);
        chk(d, 32'h0);
        rd(REG_RETRY, d);
        chk(d, 32'h0);
        $display("test classes done");
        report_and_stop();
    end
endmodule
